// File: core/acf_defines.svh
// Offsets, field positions and reset values of the converter control block
`ifndef ACF_DEFINES_SVH
`define ACF_DEFINES_SVH
// ==================================================================
// Register indices (byte address is four times the index)
`define ACF_IDX_RES_LO 8'h78
`define ACF_IDX_RES_HI 8'h79
`define ACF_IDX_SEL    8'h7C
`define ACF_IDX_STS    8'h70
`define ACF_IDX_MSK    8'h71
`define ACF_IDX_CTL    8'h72
// ==================================================================
// Field positions and reset values
`define ACF_SEL_RST    8'h00
`define ACF_SEL_REF_HI 7
`define ACF_SEL_REF_LO 6
`define ACF_SEL_ALIGN  5
`define ACF_SEL_MUX_HI 4
`define ACF_STS_DONE   0
`define ACF_STS_OVR    1
`define ACF_CTL_START  0
`define ACF_CTL_BUSY   1
// ==================================================================
// Result codes
`define ACF_RES_W      10
`define ACF_SE_MAX     10'h3FF
`define ACF_DIF_MAX    10'h1FF
`define ACF_DIF_MIN    10'h200
`endif

// File: core/acf_pkg.sv
// Types shared by the converter control block
package acf_pkg;
   // ===============================================================
   // Gain of the differential stage
   typedef enum logic [1:0]
   {
      ACF_GAIN_1   = 2'h0,
      ACF_GAIN_10  = 2'h1,
      ACF_GAIN_200 = 2'h2
   } acf_gain_t;

   // ===============================================================
   // Whole register state of the top module
   typedef struct packed
   {
      logic [7:0] sel;
      logic [7:0] app;
      logic [9:0] res;
      logic       lock;
      logic [1:0] sts;
      logic [1:0] msk;
      logic       ack;
      logic [7:0] dat;
      logic       start;
   } acf_state_t;
endpackage

// File: core/acf_sel_dec.sv
// Decoder of reference and channel/gain selection
`timescale 1ns/1ps
`default_nettype none
`include "acf_defines.svh"
module acf_sel_dec
   import acf_pkg::*;
(
   input  wire logic [7:0] sel_i,      // Applied selection byte
   output logic [3:0]      ref_o,      // One-hot reference choice
   output logic            int_ref_o,  // Internal reference on
   output logic [2:0]      pos_o,      // Positive input index
   output logic [1:0]      neg_o,      // Negative input index
   output acf_gain_t       gain_o,     // Differential gain
   output logic            diff_o,     // Differential pair routed
   output logic            bg_o,       // Bandgap routed
   output logic            gnd_o       // Ground routed
);
   logic [4:0] mux;

   assign mux = sel_i[`ACF_SEL_MUX_HI:0];

   always_comb
   begin
      ref_o     = 4'h0;
      ref_o[sel_i[`ACF_SEL_REF_HI:`ACF_SEL_REF_LO]] = 1'b1;
      int_ref_o = sel_i[`ACF_SEL_REF_HI];
      pos_o     = mux[2:0];
      neg_o     = 2'h0;
      gain_o    = ACF_GAIN_1;
      diff_o    = 1'b0;
      bg_o      = 1'b0;
      gnd_o     = 1'b0;
      case (mux[4:3])
         2'b00:  ;
         2'b01:
         begin
            pos_o  = {1'b0, mux[2], mux[0]};
            neg_o  = {mux[2], 1'b0};
            gain_o = mux[1] ? ACF_GAIN_200 : ACF_GAIN_10;
            diff_o = 1'b1;
         end
         2'b10:
         begin
            neg_o  = 2'h1;
            diff_o = 1'b1;
         end
         default:
         begin
            if (mux == 5'h1E)
               bg_o = 1'b1;
            else if (mux == 5'h1F)
               gnd_o = 1'b1;
            else
            begin
               neg_o  = 2'h2;
               diff_o = 1'b1;
            end
         end
      endcase
   end
endmodule
`default_nettype wire

// File: core/acf_fmt.sv
// Saturating formatter from raw converter value to 10-bit code
`timescale 1ns/1ps
`default_nettype none
`include "acf_defines.svh"
module acf_fmt
#(
   parameter int RAW_W = 11
)
(
   input  wire logic [RAW_W-1:0] raw_i,  // Raw converter value
   input  wire logic             diff_i, // Differential conversion
   output logic [9:0]            code_o  // Formatted result code
);
   localparam logic signed [RAW_W-1:0] DMAX = RAW_W'(511);
   localparam logic signed [RAW_W-1:0] DMIN = RAW_W'(-512);
   localparam logic [RAW_W-1:0]        UMAX = RAW_W'(1023);

   generate
      if (RAW_W < 11 || RAW_W > 16)
      begin : g_chk
         $error("acf_fmt: RAW_W must be 11 to 16");
      end
   endgenerate

   always_comb
   begin
      code_o = raw_i[9:0];
      if (diff_i)
      begin
         if ($signed(raw_i) > DMAX)
            code_o = `ACF_DIF_MAX;
         else if ($signed(raw_i) < DMIN)
            code_o = `ACF_DIF_MIN;
      end
      else if (raw_i > UMAX)
         code_o = `ACF_SE_MAX;
   end
endmodule
`default_nettype wire

// File: core/acf_top.sv
// Converter input selection, result capture and formatting with Wishbone
`timescale 1ns/1ps
`default_nettype none
`include "acf_defines.svh"
module acf_top
   import acf_pkg::*;
#(
   parameter int RAW_W = 11
)
(
   input  wire logic             clk_i,        // System clock 125 MHz
   input  wire logic             rst_b_i,      // Async reset, active low
   input  wire logic             wb_cyc_i,     // Wishbone cycle
   input  wire logic             wb_stb_i,     // Wishbone strobe
   input  wire logic             wb_we_i,      // Wishbone write enable
   input  wire logic [9:0]       wb_adr_i,     // Wishbone byte address
   input  wire logic [3:0]       wb_sel_i,     // Wishbone byte selects
   input  wire logic [31:0]      wb_dat_i,     // Wishbone write data
   output logic [31:0]           wb_dat_o,     // Wishbone read data
   output logic                  wb_ack_o,     // Wishbone acknowledge
   output logic                  irq_o,        // Level interrupt
   output logic                  conv_start_o, // Start pulse to converter
   input  wire logic             conv_busy_i,  // Conversion running
   input  wire logic             conv_done_i,  // Conversion end pulse
   input  wire logic [RAW_W-1:0] conv_raw_i,   // Raw value at done
   output logic [3:0]            ref_sel_o,    // One-hot reference
   output logic                  int_ref_o,    // Internal reference on
   output logic [2:0]            pos_ch_o,     // Positive input index
   output logic [1:0]            neg_ch_o,     // Negative input index
   output acf_gain_t             gain_o,       // Differential gain
   output logic                  diff_o,       // Differential pair
   output logic                  bandgap_o,    // Bandgap routed
   output logic                  ground_o      // Ground routed
);
   // ===============================================================
   // Declarations
   acf_state_t q;
   acf_state_t n;
   logic [7:0] idx;
   logic       req;
   logic       wr;
   logic       rd;
   logic [9:0] code;

   generate
      if (RAW_W < 11 || RAW_W > 16)
      begin : g_chk
         $error("acf_top: RAW_W must be 11 to 16");
      end
   endgenerate

   // ===============================================================
   // Register read decode
   function automatic logic [7:0] rd_byte
   (
      input logic [7:0] a,
      input acf_state_t s,
      input logic       busy
   );
      logic al;
      al = s.sel[`ACF_SEL_ALIGN];
      case (a)
         `ACF_IDX_RES_LO:
            rd_byte = al ? {s.res[1:0], 6'h00} : s.res[7:0];
         `ACF_IDX_RES_HI:
            rd_byte = al ? s.res[9:2] : {6'h00, s.res[9:8]};
         `ACF_IDX_SEL:
            rd_byte = s.sel;
         `ACF_IDX_STS:
            rd_byte = {6'h00, s.sts};
         `ACF_IDX_MSK:
            rd_byte = {6'h00, s.msk};
         `ACF_IDX_CTL:
            rd_byte = {6'h00, busy, 1'b0};
         default:
            rd_byte = 8'h00;
      endcase
   endfunction

   // ===============================================================
   // Sub-blocks
   acf_sel_dec u_dec
   (
      .sel_i     (q.app),
      .ref_o     (ref_sel_o),
      .int_ref_o (int_ref_o),
      .pos_o     (pos_ch_o),
      .neg_o     (neg_ch_o),
      .gain_o    (gain_o),
      .diff_o    (diff_o),
      .bg_o      (bandgap_o),
      .gnd_o     (ground_o)
   );

   acf_fmt #(.RAW_W(RAW_W)) u_fmt
   (
      .raw_i  (conv_raw_i),
      .diff_i (diff_o),
      .code_o (code)
   );

   // ===============================================================
   // Bus request decode
   assign idx = wb_adr_i[9:2];
   assign req = wb_cyc_i & wb_stb_i & ~q.ack;
   assign wr  = req & wb_we_i & wb_sel_i[0];
   assign rd  = req & ~wb_we_i;

   // ===============================================================
   // Next state
   always_comb
   begin
      n       = q;
      n.ack   = req;
      n.start = 1'b0;
      // Settings reach the converter only between conversions
      n.app   = conv_busy_i ? q.app : q.sel;
      if (rd)
         n.dat = rd_byte(idx, q, conv_busy_i);
      if (wr)
      begin
         case (idx)
            `ACF_IDX_SEL: n.sel = wb_dat_i[7:0];
            `ACF_IDX_MSK: n.msk = wb_dat_i[1:0];
            `ACF_IDX_CTL: n.start = wb_dat_i[`ACF_CTL_START];
            default:      ;
         endcase
      end
      if (rd && idx == `ACF_IDX_STS)
         n.sts = 2'h0;
      if (rd && idx == `ACF_IDX_RES_LO)
         n.lock = 1'b1;
      if (rd && idx == `ACF_IDX_RES_HI)
         n.lock = 1'b0;
      // Events win over a clearing read in the same cycle
      if (conv_done_i)
      begin
         if (!q.lock)
         begin
            n.res = code;
            n.sts[`ACF_STS_DONE] = 1'b1;
         end
         else
            n.sts[`ACF_STS_OVR] = 1'b1;
      end
   end

   // ===============================================================
   // State register
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         q       <= '0;
         q.sel   <= `ACF_SEL_RST;
         q.app   <= `ACF_SEL_RST;
      end
      else
         q <= n;
   end

   // ===============================================================
   // Outputs
   assign wb_ack_o     = q.ack;
   assign wb_dat_o     = {24'h000000, q.dat};
   assign conv_start_o = q.start;
   assign irq_o        = |(q.sts & q.msk);

   // ===============================================================
   // Assertions
   property p_done_upd;
      @(posedge clk_i) disable iff (!rst_b_i)
      conv_done_i && !q.lock |=>
         q.res == $past(code) && q.sts[`ACF_STS_DONE];
   endproperty
   a_done_upd: assert property (p_done_upd)
      else $error("result or done flag not updated at conversion end");

   property p_se_sat;
      @(posedge clk_i) disable iff (!rst_b_i)
      conv_done_i && !q.lock && !diff_o &&
         conv_raw_i > RAW_W'(1023) |=> q.res == 10'h3FF;
   endproperty
   a_se_sat: assert property (p_se_sat)
      else $error("single-ended overrange not clamped to 0x3FF");

   property p_dif_sat;
      @(posedge clk_i) disable iff (!rst_b_i)
      conv_done_i && !q.lock && diff_o &&
         $signed(conv_raw_i) < $signed(RAW_W'(-512)) |=> q.res == 10'h200;
   endproperty
   a_dif_sat: assert property (p_dif_sat)
      else $error("differential underrange not clamped to 0x200");

   property p_sign;
      @(posedge clk_i) disable iff (!rst_b_i)
      conv_done_i && !q.lock && diff_o |=>
         q.res[9] == $past(conv_raw_i[RAW_W-1]);
   endproperty
   a_sign: assert property (p_sign)
      else $error("result sign bit does not follow input polarity");

   property p_sel_wr;
      @(posedge clk_i) disable iff (!rst_b_i)
      wr && idx == `ACF_IDX_SEL |=> q.sel == $past(wb_dat_i[7:0]);
   endproperty
   a_sel_wr: assert property (p_sel_wr)
      else $error("selection register did not take written value");

   property p_ref;
      @(posedge clk_i) disable iff (!rst_b_i)
      q.app[7:6] == 2'b11 |-> ref_sel_o == 4'h8 && int_ref_o;
   endproperty
   a_ref: assert property (p_ref)
      else $error("2.56V reference code not decoded");

   property p_hold;
      @(posedge clk_i) disable iff (!rst_b_i)
      conv_busy_i && $past(conv_busy_i) |-> $stable(q.app);
   endproperty
   a_hold: assert property (p_hold)
      else $error("applied selection changed during conversion");

   property p_align;
      @(posedge clk_i) disable iff (!rst_b_i)
      rd && idx == `ACF_IDX_RES_HI && q.sel[5] |=>
         wb_ack_o && wb_dat_o[7:0] == $past(q.res[9:2]);
   endproperty
   a_align: assert property (p_align)
      else $error("left aligned high byte wrong");

   property p_pair;
      @(posedge clk_i) disable iff (!rst_b_i)
      q.app[4:3] == 2'b01 |->
         diff_o && neg_ch_o == {q.app[2], 1'b0} &&
         gain_o == (q.app[1] ? ACF_GAIN_200 : ACF_GAIN_10);
   endproperty
   a_pair: assert property (p_pair)
      else $error("gain pair code decoded wrongly");

   property p_lock;
      @(posedge clk_i) disable iff (!rst_b_i)
      q.lock && conv_done_i |=> $stable(q.res) && q.sts[`ACF_STS_OVR];
   endproperty
   a_lock: assert property (p_lock)
      else $error("result changed while low byte lock held");

   property p_ref_ext;
      @(posedge clk_i) disable iff (!rst_b_i)
      q.app[7:6] == 2'b00 |-> ref_sel_o == 4'h1 && !int_ref_o;
   endproperty
   a_ref_ext: assert property (p_ref_ext)
      else $error("external reference code not decoded");

   property p_ref_bg;
      @(posedge clk_i) disable iff (!rst_b_i)
      q.app[7:6] == 2'b10 |-> ref_sel_o == 4'h4 && int_ref_o;
   endproperty
   a_ref_bg: assert property (p_ref_bg)
      else $error("1.1V reference code not decoded");

   property p_se_route;
      @(posedge clk_i) disable iff (!rst_b_i)
      q.app[4:3] == 2'b00 |->
         !diff_o && !bandgap_o && !ground_o && pos_ch_o == q.app[2:0];
   endproperty
   a_se_route: assert property (p_se_route)
      else $error("single-ended input code decoded wrongly");

   property p_bg_route;
      @(posedge clk_i) disable iff (!rst_b_i)
      q.app[4:0] == 5'h1E |-> bandgap_o && !ground_o && !diff_o;
   endproperty
   a_bg_route: assert property (p_bg_route)
      else $error("bandgap code decoded wrongly");

   property p_gnd_route;
      @(posedge clk_i) disable iff (!rst_b_i)
      q.app[4:0] == 5'h1F |-> ground_o && !bandgap_o && !diff_o;
   endproperty
   a_gnd_route: assert property (p_gnd_route)
      else $error("ground code decoded wrongly");

   property p_pair_pos;
      @(posedge clk_i) disable iff (!rst_b_i)
      q.app[4:3] == 2'b01 |-> pos_ch_o == {1'b0, q.app[2], q.app[0]};
   endproperty
   a_pair_pos: assert property (p_pair_pos)
      else $error("gain pair positive input wrong");

   property p_unity_a;
      @(posedge clk_i) disable iff (!rst_b_i)
      q.app[4:3] == 2'b10 |->
         diff_o && neg_ch_o == 2'h1 && gain_o == ACF_GAIN_1 &&
         pos_ch_o == q.app[2:0];
   endproperty
   a_unity_a: assert property (p_unity_a)
      else $error("unity pair against input 1 decoded wrongly");

   property p_unity_b;
      @(posedge clk_i) disable iff (!rst_b_i)
      q.app[4:3] == 2'b11 && q.app[2:1] != 2'b11 |->
         diff_o && neg_ch_o == 2'h2 && gain_o == ACF_GAIN_1 &&
         pos_ch_o == q.app[2:0];
   endproperty
   a_unity_b: assert property (p_unity_b)
      else $error("unity pair against input 2 decoded wrongly");

   property p_dif_top;
      @(posedge clk_i) disable iff (!rst_b_i)
      conv_done_i && !q.lock && diff_o &&
         $signed(conv_raw_i) > $signed(RAW_W'(511)) |=> q.res == 10'h1FF;
   endproperty
   a_dif_top: assert property (p_dif_top)
      else $error("differential overrange not clamped to 0x1FF");

   property p_right_hi;
      @(posedge clk_i) disable iff (!rst_b_i)
      rd && idx == `ACF_IDX_RES_HI && !q.sel[5] |=>
         wb_dat_o[7:0] == {6'h00, $past(q.res[9:8])};
   endproperty
   a_right_hi: assert property (p_right_hi)
      else $error("right aligned high byte wrong");

   property p_left_lo;
      @(posedge clk_i) disable iff (!rst_b_i)
      rd && idx == `ACF_IDX_RES_LO && q.sel[5] |=>
         wb_dat_o[7:0] == {$past(q.res[1:0]), 6'h00};
   endproperty
   a_left_lo: assert property (p_left_lo)
      else $error("left aligned low byte wrong");
endmodule
`default_nettype wire

// File: dv/tb_acf_top.sv
// Self-checking testbench of the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb_acf_top
   import acf_pkg::*;
;
   logic        clk_i, rst_b_i, cyc, stb, we, ack, irq, start;
   logic        busy, done, int_ref, diff, bg, gnd;
   logic [9:0]  adr;
   logic [31:0] wdat, rdat;
   logic [3:0]  wsel, ref_sel;
   logic [10:0] raw, r;
   logic [2:0]  pos;
   logic [1:0]  neg;
   acf_gain_t   gain;
   logic [7:0]  s;
   logic [9:0]  e;
   logic [31:0] expq[$];
   int          fails, compares, starts;

   acf_top #(.RAW_W(11)) uut
   (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(wsel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .conv_start_o(start),
      .conv_busy_i(busy), .conv_done_i(done), .conv_raw_i(raw),
      .ref_sel_o(ref_sel), .int_ref_o(int_ref), .pos_ch_o(pos),
      .neg_ch_o(neg), .gain_o(gain), .diff_o(diff), .bandgap_o(bg),
      .ground_o(gnd)
   );

   always #4 clk_i = ~clk_i;

   task check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task stop_test;
      $display("Mismatches %0d, comparisons %0d", fails, compares);
      if (fails == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ===============================================================
   // Classic Wishbone single cycle
   task bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= {idx, 2'b00};
      wdat <= {24'h0, d};
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      if (n >= 20)
         fails++;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task wr(input logic [7:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
   endtask

   task rd(input logic [7:0] idx, input logic [7:0] x);
      expq.push_back({24'h0, x});
      bus(1'b0, idx, 8'h00);
   endtask

   // Read data is judged against the oldest note
   always @(negedge clk_i)
   begin
      if (ack === 1'b1 && we === 1'b0)
      begin
         if (expq.size() == 0)
            fails++;
         else
            check(rdat, expq.pop_front());
      end
   end

   // Start pulses seen at rising edges
   always @(posedge clk_i)
      if (start === 1'b1)
         starts++;

   // ===============================================================
   // Expected values
   // {diff, bandgap, ground, pos, neg, gain}
   function automatic logic [9:0] exp_dec(input logic [4:0] m);
      logic       d;
      logic [2:0] p;
      logic [1:0] n, g;
      d = (m[4:3] != 2'b00) && (m[4:1] != 4'hF);
      p = m[2:0];
      n = 2'h1;
      g = 2'h0;
      if (m[4:3] == 2'b01)
      begin
         p = {1'b0, m[2], m[0]};
         n = m[2] ? 2'h2 : 2'h0;
         g = m[1] ? 2'h2 : 2'h1;
      end
      else if (m[4:3] == 2'b11)
         n = 2'h2;
      return {d, m == 5'h1E, m == 5'h1F, p, n, g};
   endfunction

   function automatic logic [9:0] fmt(input logic [10:0] v, input logic d);
      if (!d)
         return (v > 11'h3FF) ? 10'h3FF : v[9:0];
      if (!v[10] && v[9])
         return 10'h1FF;
      if (v[10] && !v[9])
         return 10'h200;
      return v[9:0];
   endfunction

   task conv(input logic [10:0] v);
      @(posedge clk_i);
      done <= 1'b1;
      raw  <= v;
      busy <= 1'b0;
      @(posedge clk_i);
      done <= 1'b0;
      raw  <= ~v;
   endtask

   task rdres(input logic [9:0] v, input logic al);
      rd(8'h78, al ? {v[1:0], 6'h00} : v[7:0]);
      rd(8'h79, al ? v[9:2] : {6'h00, v[9:8]});
   endtask

   // ===============================================================
   // Main sequence
   initial
   begin
      clk_i = 0; rst_b_i = 0; cyc = 0; stb = 0; we = 0; adr = 0;
      wdat = 0; wsel = 4'hF; busy = 0; done = 0; raw = 0;
      void'($urandom(32'hA29A));
      repeat (10) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(negedge clk_i);
      check({ref_sel, int_ref, diff}, 6'h04);
      rd(8'h7C, 8'h00);
      rd(8'h6F, 8'h00);
      wr(8'h71, 8'h03);
      wr(8'h72, 8'h01);
      @(negedge clk_i);
      check(starts, 1);
      for (int m = 0; m < 32; m++)
      begin
         e = exp_dec(m[4:0]);
         s = {m[1:0], 1'($urandom), m[4:0]};
         if (e[9] && s[7:6] == 2'b10)
            s[7:6] = 2'b11;
         wr(8'h7C, s);
         repeat (2) @(negedge clk_i);
         check({ref_sel, int_ref}, {4'h1 << s[7:6], s[7]});
         if (e[9])
            check({diff, bg, gnd, pos, neg, gain}, e);
         else
            check({diff, bg, gnd}, e[9:7]);
         if (m < 8)
            check(pos, m[2:0]);
         rd(8'h7C, s);
         r = 11'($urandom);
         conv(r);
         @(negedge clk_i);
         check(irq, 1'b1);
         rdres(fmt(r, e[9]), s[5]);
         wr(8'h7C, s ^ 8'h20);
         rdres(fmt(r, e[9]), ~s[5]);
         rd(8'h70, 8'h01);
         check(irq, 1'b0);
      end
      // Masked event keeps the line low
      wr(8'h71, 8'h00);
      conv(11'h123);
      @(negedge clk_i);
      check(irq, 1'b0);
      rd(8'h70, 8'h01);
      wr(8'h71, 8'h03);
      // Result held between low and high byte reads
      wr(8'h7C, 8'h00);
      conv(11'h155);
      rd(8'h78, 8'h55);
      conv(11'h2AA);
      rd(8'h79, 8'h01);
      rd(8'h70, 8'h03);
      conv(11'h0AA);
      rdres(10'h0AA, 1'b0);
      rd(8'h70, 8'h01);
      // Selection frozen during a conversion
      @(posedge clk_i);
      busy <= 1'b1;
      wr(8'h7C, 8'hC9);
      rd(8'h72, 8'h02);
      repeat (3) @(negedge clk_i);
      check({ref_sel, pos, diff}, {4'h1, 3'h0, 1'b0});
      conv(11'h600);
      @(negedge clk_i);
      check({ref_sel, pos, diff}, {4'h8, 3'h1, 1'b1});
      rdres(10'h3FF, 1'b0);
      conv(11'h600);
      rdres(10'h200, 1'b0);
      stop_test();
   end

   initial
   begin
      repeat (20000) @(posedge clk_i);
      fails++;
      stop_test();
   end
endmodule
`default_nettype wire
